// ==== rtl/iosd_regs.vh ====
`ifndef IOSD_REGS_VH
`define IOSD_REGS_VH

// Access kinds presented by the core
`define IOSD_K_IN 3'h0
`define IOSD_K_OUT 3'h1
`define IOSD_K_LOAD 3'h2
`define IOSD_K_STORE 3'h3
`define IOSD_K_SET 3'h4
`define IOSD_K_CLR 3'h5
`define IOSD_K_SKIPH 3'h6
`define IOSD_K_SKIPL 3'h7

// Address space limits
`define IOSD_IO_LAST 8'h3F
`define IOSD_BIT_LAST 8'h1F
`define IOSD_DATA_OFS 8'h20
`define IOSD_EXT_FIRST 8'h60
`define IOSD_EXT_LAST 8'hFF
`define IOSD_SLOTS 224
`define IOSD_RST 8'h00

// Data-space addresses
`define IOSD_A_BIN 8'h23
`define IOSD_A_BDIR 8'h24
`define IOSD_A_BOUT 8'h25
`define IOSD_A_CIN 8'h26
`define IOSD_A_CDIR 8'h27
`define IOSD_A_COUT 8'h28
`define IOSD_A_DIN 8'h29
`define IOSD_A_DDIR 8'h2A
`define IOSD_A_DOUT 8'h2B
`define IOSD_A_AIN 8'h2C
`define IOSD_A_ADIR 8'h2D
`define IOSD_A_AOUT 8'h2E
`define IOSD_A_PCTL 8'h32
`define IOSD_A_TFLG0 8'h35
`define IOSD_A_TFLG1 8'h36
`define IOSD_A_XIEN 8'h3D
`define IOSD_A_SCR0 8'h3E
`define IOSD_A_EECTL 8'h3F
`define IOSD_A_EEDAT 8'h40
`define IOSD_A_EEADR 8'h41
`define IOSD_A_PSYNC 8'h43
`define IOSD_A_T0CTL 8'h45
`define IOSD_A_T0CNT 8'h46
`define IOSD_A_T0CMA 8'h47
`define IOSD_A_T0CMB 8'h48
`define IOSD_A_SCR1 8'h4A
`define IOSD_A_SCR2 8'h4B
`define IOSD_A_SPCTL 8'h4C
`define IOSD_A_SPSTA 8'h4D
`define IOSD_A_SPDAT 8'h4E
`define IOSD_A_CMPCS 8'h50
`define IOSD_A_DBGD 8'h51
`define IOSD_A_SLPC 8'h53
`define IOSD_A_RSTC 8'h54
`define IOSD_A_CORC 8'h55
`define IOSD_A_SPMC 8'h57
`define IOSD_A_STKL 8'h5D
`define IOSD_A_PSTAT 8'h5F
`define IOSD_A_WDTC 8'h60
`define IOSD_A_CLKD 8'h61
`define IOSD_A_PWRG 8'h64
`define IOSD_A_OSCT 8'h66
`define IOSD_A_PCIEN 8'h68
`define IOSD_A_EISNS 8'h69
`define IOSD_A_PCM3 8'h6A
`define IOSD_A_PCM0 8'h6B
`define IOSD_A_PCM1 8'h6C
`define IOSD_A_PCM2 8'h6D

// Bit masks: full, none, and the implemented or writable bits of partly reserved registers
`define IOSD_M_FULL 8'hFF
`define IOSD_M_NONE 8'h00
`define IOSD_M_PTA4 8'h0F
`define IOSD_M_TFLG0 8'h07
`define IOSD_M_TFLG1 8'h27
`define IOSD_M_XIEN 8'h03
`define IOSD_M_EECTL 8'h3F
`define IOSD_M_PSYNC 8'h81
`define IOSD_M_T0CTL 8'h0F
`define IOSD_M_SPSTA 8'hC1
`define IOSD_M_SPSTW 8'h01
`define IOSD_M_CMPCS 8'hEF
`define IOSD_M_SLPC 8'h07
`define IOSD_M_RSTC 8'h0F
`define IOSD_M_CORC 8'h70
`define IOSD_M_SPMC 8'h5F
`define IOSD_M_CLKD 8'h8F
`define IOSD_M_PWRG 8'hAD
`define IOSD_M_LOW4 8'h0F

`endif

// ==== rtl/iosd_flag_reg.v ====
`include "iosd_regs.vh"

module iosd_flag_reg #(
  parameter [7:0] MASK = 8'hFF
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire reset_n_i,
  // Events and clears
  input wire [7:0] set_i,
  input wire [7:0] clr_i,
  // Flag state
  output wire [7:0] flags_o
);

  reg [7:0] flags_q;

  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_bit
      always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
          flags_q[b] <= 1'b0;
        end else if (!MASK[b]) begin
          flags_q[b] <= 1'b0;
        end else if (set_i[b]) begin
          // Event beats a clear in the same cycle
          flags_q[b] <= 1'b1;
        end else if (clr_i[b]) begin
          flags_q[b] <= 1'b0;
        end
      end
    end
  endgenerate

  assign flags_o = flags_q;

endmodule // iosd_flag_reg

// ==== rtl/iosd_addr_map.v ====
`include "iosd_regs.vh"

module iosd_addr_map (
  // Access as issued
  input wire [2:0] kind_i,
  input wire [7:0] addr_i,
  // Decoded target
  output reg [7:0] daddr_o,
  output reg legal_o,
  output reg [7:0] rmask_o,
  output reg [7:0] wmask_o,
  output reg [7:0] w1c_o
);

  always @* begin
    daddr_o = addr_i;
    legal_o = 1'b0;
    case (kind_i)
      `IOSD_K_IN, `IOSD_K_OUT: begin
        // Six-bit I/O field, shifted into data space
        legal_o = (addr_i <= `IOSD_IO_LAST);
        daddr_o = addr_i + `IOSD_DATA_OFS;
      end
      `IOSD_K_SET, `IOSD_K_CLR, `IOSD_K_SKIPH, `IOSD_K_SKIPL: begin
        legal_o = (addr_i <= `IOSD_BIT_LAST);
        daddr_o = addr_i + `IOSD_DATA_OFS;
      end
      `IOSD_K_LOAD, `IOSD_K_STORE: begin
        // Below the offset sit the working registers, not ours
        legal_o = (addr_i >= `IOSD_DATA_OFS);
        daddr_o = addr_i;
      end
      default: begin
        legal_o = 1'b0;
      end
    endcase
  end

  always @* begin
    rmask_o = `IOSD_M_NONE;
    wmask_o = `IOSD_M_NONE;
    w1c_o = `IOSD_M_NONE;
    case (daddr_o)
      `IOSD_A_BIN, `IOSD_A_CIN, `IOSD_A_DIN: begin
        rmask_o = `IOSD_M_FULL;
      end
      `IOSD_A_AIN: begin
        rmask_o = `IOSD_M_PTA4;
      end
      `IOSD_A_ADIR, `IOSD_A_AOUT: begin
        rmask_o = `IOSD_M_PTA4;
        wmask_o = `IOSD_M_PTA4;
      end
      `IOSD_A_TFLG0: begin
        rmask_o = `IOSD_M_TFLG0;
        w1c_o = `IOSD_M_TFLG0;
      end
      `IOSD_A_TFLG1: begin
        rmask_o = `IOSD_M_TFLG1;
        w1c_o = `IOSD_M_TFLG1;
      end
      `IOSD_A_XIEN: begin
        rmask_o = `IOSD_M_XIEN;
        wmask_o = `IOSD_M_XIEN;
      end
      `IOSD_A_EECTL: begin
        rmask_o = `IOSD_M_EECTL;
        wmask_o = `IOSD_M_EECTL;
      end
      `IOSD_A_PSYNC: begin
        rmask_o = `IOSD_M_PSYNC;
        wmask_o = `IOSD_M_PSYNC;
      end
      `IOSD_A_T0CTL: begin
        rmask_o = `IOSD_M_T0CTL;
        wmask_o = `IOSD_M_T0CTL;
      end
      `IOSD_A_SPSTA: begin
        rmask_o = `IOSD_M_SPSTA;
        wmask_o = `IOSD_M_SPSTW;
      end
      `IOSD_A_CMPCS: begin
        rmask_o = `IOSD_M_CMPCS;
        wmask_o = `IOSD_M_CMPCS;
      end
      `IOSD_A_SLPC: begin
        rmask_o = `IOSD_M_SLPC;
        wmask_o = `IOSD_M_SLPC;
      end
      `IOSD_A_RSTC: begin
        rmask_o = `IOSD_M_RSTC;
        wmask_o = `IOSD_M_RSTC;
      end
      `IOSD_A_CORC: begin
        rmask_o = `IOSD_M_CORC;
        wmask_o = `IOSD_M_CORC;
      end
      `IOSD_A_SPMC: begin
        rmask_o = `IOSD_M_SPMC;
        wmask_o = `IOSD_M_SPMC;
      end
      `IOSD_A_CLKD: begin
        rmask_o = `IOSD_M_CLKD;
        wmask_o = `IOSD_M_CLKD;
      end
      `IOSD_A_PWRG: begin
        rmask_o = `IOSD_M_PWRG;
        wmask_o = `IOSD_M_PWRG;
      end
      `IOSD_A_PCIEN, `IOSD_A_EISNS, `IOSD_A_PCM3: begin
        rmask_o = `IOSD_M_LOW4;
        wmask_o = `IOSD_M_LOW4;
      end
      `IOSD_A_BDIR, `IOSD_A_BOUT, `IOSD_A_CDIR, `IOSD_A_COUT,
      `IOSD_A_DDIR, `IOSD_A_DOUT, `IOSD_A_PCTL, `IOSD_A_SCR0,
      `IOSD_A_EEDAT, `IOSD_A_EEADR, `IOSD_A_T0CNT, `IOSD_A_T0CMA,
      `IOSD_A_T0CMB, `IOSD_A_SCR1, `IOSD_A_SCR2, `IOSD_A_SPCTL,
      `IOSD_A_SPDAT, `IOSD_A_DBGD, `IOSD_A_STKL, `IOSD_A_PSTAT,
      `IOSD_A_WDTC, `IOSD_A_OSCT, `IOSD_A_PCM0, `IOSD_A_PCM1,
      `IOSD_A_PCM2: begin
        rmask_o = `IOSD_M_FULL;
        wmask_o = `IOSD_M_FULL;
      end
      default: begin
        // Reserved location: reads zero, writes dropped
        rmask_o = `IOSD_M_NONE;
        wmask_o = `IOSD_M_NONE;
      end
    endcase
  end

endmodule // iosd_addr_map

// ==== rtl/iosd_top.v ====
`include "iosd_regs.vh"

module iosd_top (
  // Clock and reset
  input wire ref_clk_i,
  input wire reset_n_i,
  // Core access request
  input wire acc_req_i,
  input wire [2:0] acc_kind_i,
  input wire [7:0] acc_addr_i,
  input wire [2:0] acc_bit_i,
  input wire [7:0] acc_wdata_i,
  // Core access answer
  output wire acc_done_o,
  output wire [7:0] acc_rdata_o,
  output wire acc_skip_o,
  output wire acc_err_o,
  // Port pin levels
  input wire [7:0] port_a_pin_i,
  input wire [7:0] port_b_pin_i,
  input wire [7:0] port_c_pin_i,
  input wire [7:0] port_d_pin_i,
  // Port direction and output values
  output wire [7:0] port_a_dir_o,
  output wire [7:0] port_a_out_o,
  output wire [7:0] port_b_dir_o,
  output wire [7:0] port_b_out_o,
  output wire [7:0] port_c_dir_o,
  output wire [7:0] port_c_out_o,
  output wire [7:0] port_d_dir_o,
  output wire [7:0] port_d_out_o,
  // Timer event strobes
  input wire [7:0] tmr0_evt_i,
  input wire [7:0] tmr1_evt_i
);

  localparam [7:0] IX_AIN = `IOSD_A_AIN - `IOSD_DATA_OFS;
  localparam [7:0] IX_ADIR = `IOSD_A_ADIR - `IOSD_DATA_OFS;
  localparam [7:0] IX_AOUT = `IOSD_A_AOUT - `IOSD_DATA_OFS;
  localparam [7:0] IX_BIN = `IOSD_A_BIN - `IOSD_DATA_OFS;
  localparam [7:0] IX_BDIR = `IOSD_A_BDIR - `IOSD_DATA_OFS;
  localparam [7:0] IX_BOUT = `IOSD_A_BOUT - `IOSD_DATA_OFS;
  localparam [7:0] IX_CIN = `IOSD_A_CIN - `IOSD_DATA_OFS;
  localparam [7:0] IX_CDIR = `IOSD_A_CDIR - `IOSD_DATA_OFS;
  localparam [7:0] IX_COUT = `IOSD_A_COUT - `IOSD_DATA_OFS;
  localparam [7:0] IX_DIN = `IOSD_A_DIN - `IOSD_DATA_OFS;
  localparam [7:0] IX_DDIR = `IOSD_A_DDIR - `IOSD_DATA_OFS;
  localparam [7:0] IX_DOUT = `IOSD_A_DOUT - `IOSD_DATA_OFS;

  // Decode
  wire [7:0] daddr;
  wire legal;
  wire [7:0] rmask;
  wire [7:0] wmask;
  wire [7:0] w1c;
  wire [7:0] idx;
  wire in_space;

  iosd_addr_map u_map (
    .kind_i(acc_kind_i),
    .addr_i(acc_addr_i),
    .daddr_o(daddr),
    .legal_o(legal),
    .rmask_o(rmask),
    .wmask_o(wmask),
    .w1c_o(w1c)
  );

  assign idx = daddr - `IOSD_DATA_OFS;
  assign in_space = (daddr >= `IOSD_DATA_OFS);

  // Storage and flag state
  reg [7:0] mem_q [0:`IOSD_SLOTS-1];
  wire [7:0] tflg0;
  wire [7:0] tflg1;
  reg [7:0] clr0;
  reg [7:0] clr1;

  // Access classification
  reg is_write;
  reg is_read;
  reg is_skip;
  wire take;
  wire [7:0] bit_vec;
  reg [7:0] raw_val;
  wire [7:0] rd_val;
  reg [7:0] new_val;
  reg [7:0] clr_vec;
  wire wr_en;
  wire sel_bit;

  assign take = acc_req_i & legal;
  assign bit_vec = 8'h01 << acc_bit_i;
  assign wr_en = take & is_write;

  always @* begin
    is_write = 1'b0;
    is_read = 1'b0;
    is_skip = 1'b0;
    case (acc_kind_i)
      `IOSD_K_IN, `IOSD_K_LOAD: begin
        is_read = 1'b1;
      end
      `IOSD_K_OUT, `IOSD_K_STORE, `IOSD_K_SET, `IOSD_K_CLR: begin
        is_write = 1'b1;
      end
      `IOSD_K_SKIPH, `IOSD_K_SKIPL: begin
        is_skip = 1'b1;
      end
      default: begin
        is_read = 1'b0;
      end
    endcase
  end

  // Current value of the addressed location
  always @* begin
    raw_val = `IOSD_RST;
    if (daddr == `IOSD_A_TFLG0) begin
      raw_val = tflg0;
    end else if (daddr == `IOSD_A_TFLG1) begin
      raw_val = tflg1;
    end else if (in_space) begin
      raw_val = mem_q[idx];
    end
  end

  assign rd_val = raw_val & rmask;
  assign sel_bit = rd_val[acc_bit_i];

  // Value to store and flags to clear
  always @* begin
    new_val = acc_wdata_i;
    clr_vec = `IOSD_M_NONE;
    case (acc_kind_i)
      `IOSD_K_OUT, `IOSD_K_STORE: begin
        new_val = acc_wdata_i;
        clr_vec = acc_wdata_i & w1c;
      end
      `IOSD_K_SET: begin
        // Only the addressed bit may count as a written one
        new_val = rd_val | bit_vec;
        clr_vec = bit_vec & w1c;
      end
      `IOSD_K_CLR: begin
        new_val = rd_val & ~bit_vec;
        clr_vec = `IOSD_M_NONE;
      end
      default: begin
        new_val = acc_wdata_i;
        clr_vec = `IOSD_M_NONE;
      end
    endcase
  end

  always @* begin
    clr0 = `IOSD_M_NONE;
    clr1 = `IOSD_M_NONE;
    if (wr_en && daddr == `IOSD_A_TFLG0) begin
      clr0 = clr_vec;
    end
    if (wr_en && daddr == `IOSD_A_TFLG1) begin
      clr1 = clr_vec;
    end
  end

  iosd_flag_reg #(
    .MASK(`IOSD_M_TFLG0)
  ) u_tflg0 (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .set_i(tmr0_evt_i),
    .clr_i(clr0),
    .flags_o(tflg0)
  );

  iosd_flag_reg #(
    .MASK(`IOSD_M_TFLG1)
  ) u_tflg1 (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .set_i(tmr1_evt_i),
    .clr_i(clr1),
    .flags_o(tflg1)
  );

  // One always per location; pin slots follow their inputs
  genvar e;
  generate
    for (e = 0; e < `IOSD_SLOTS; e = e + 1) begin : g_slot
      wire hit;
      wire [7:0] pin_val;
      wire is_pin;

      assign hit = wr_en && (idx == e);
      assign is_pin = (e == IX_AIN) || (e == IX_BIN) ||
                      (e == IX_CIN) || (e == IX_DIN);
      assign pin_val = (e == IX_AIN) ? (port_a_pin_i & `IOSD_M_PTA4) :
                       (e == IX_BIN) ? port_b_pin_i :
                       (e == IX_CIN) ? port_c_pin_i :
                       (e == IX_DIN) ? port_d_pin_i : `IOSD_RST;

      always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
          mem_q[e] <= `IOSD_RST;
        end else if (is_pin) begin
          mem_q[e] <= pin_val;
        end else if (hit) begin
          // Reserved and read-only bits keep their value
          mem_q[e] <= (new_val & wmask) | (mem_q[e] & ~wmask);
        end
      end
    end
  endgenerate

  // Answer registers
  reg done_q;
  reg [7:0] rdata_q;
  reg skip_q;
  reg err_q;

  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      done_q <= 1'b0;
      rdata_q <= `IOSD_RST;
      skip_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      done_q <= acc_req_i;
      // Out-of-range forms are refused, not wrapped
      err_q <= acc_req_i & ~legal;
      if (take && is_read) begin
        rdata_q <= rd_val;
      end else begin
        rdata_q <= `IOSD_RST;
      end
      if (take && is_skip) begin
        if (acc_kind_i == `IOSD_K_SKIPH) begin
          skip_q <= sel_bit;
        end else begin
          skip_q <= ~sel_bit;
        end
      end else begin
        skip_q <= 1'b0;
      end
    end
  end

  assign acc_done_o = done_q;
  assign acc_rdata_o = rdata_q;
  assign acc_skip_o = skip_q;
  assign acc_err_o = err_q;

  assign port_a_dir_o = mem_q[IX_ADIR];
  assign port_a_out_o = mem_q[IX_AOUT];
  assign port_b_dir_o = mem_q[IX_BDIR];
  assign port_b_out_o = mem_q[IX_BOUT];
  assign port_c_dir_o = mem_q[IX_CDIR];
  assign port_c_out_o = mem_q[IX_COUT];
  assign port_d_dir_o = mem_q[IX_DDIR];
  assign port_d_out_o = mem_q[IX_DOUT];

endmodule // iosd_top

// ==== bench/iosd_top_assertions.sv ====
`include "iosd_regs.vh"

module iosd_chk (
  // Clock and reset
  input wire ref_clk_i,
  input wire reset_n_i,
  // Core access
  input wire acc_req_i,
  input wire [2:0] acc_kind_i,
  input wire [7:0] acc_addr_i,
  input wire [2:0] acc_bit_i,
  input wire [7:0] acc_wdata_i,
  input wire acc_done_o,
  input wire [7:0] acc_rdata_o,
  input wire acc_skip_o,
  input wire acc_err_o,
  // Port B registers
  input wire [7:0] port_b_dir_o,
  input wire [7:0] port_b_out_o
);
  logic io_k;
  logic bit_k;
  logic mem_k;
  logic bsel;
  assign io_k = acc_req_i && acc_kind_i <= `IOSD_K_OUT;
  assign bit_k = acc_req_i && acc_kind_i >= `IOSD_K_SET;
  assign mem_k = acc_req_i && (acc_kind_i == `IOSD_K_LOAD || acc_kind_i == `IOSD_K_STORE);
  assign bsel = port_b_out_o[acc_bit_i] ^ (acc_kind_i == `IOSD_K_SKIPL);

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_set_b;
    acc_req_i && acc_kind_i == `IOSD_K_SET && acc_addr_i == 8'h05;
  endsequence
  sequence s_clr_b;
    acc_req_i && acc_kind_i == `IOSD_K_CLR && acc_addr_i == 8'h05;
  endsequence
  sequence s_skip_b;
    acc_req_i && acc_kind_i >= `IOSD_K_SKIPH && acc_addr_i == 8'h05;
  endsequence

  a_done_next: assert property (acc_req_i |=> acc_done_o)
    else $error("answer missing");
  a_done_idle: assert property (!acc_req_i |=> !acc_done_o && !acc_err_o)
    else $error("answer without request");
  a_io_range: assert property (io_k |=> acc_err_o == ($past(acc_addr_i) > 8'h3F))
    else $error("io range wrong");
  a_bit_range: assert property (bit_k |=> acc_err_o == ($past(acc_addr_i) > 8'h1F))
    else $error("bit range wrong");
  a_mem_range: assert property (mem_k |=> acc_err_o == ($past(acc_addr_i) < 8'h20))
    else $error("data range wrong");
  a_err_quiet: assert property (acc_err_o |-> acc_rdata_o == 8'h00 && !acc_skip_o)
    else $error("refused access returned data");
  a_set_one: assert property (s_set_b |=> port_b_out_o ==
    ($past(port_b_out_o) | (8'h01 << $past(acc_bit_i)))) else $error("bit set wrong");
  a_clr_one: assert property (s_clr_b |=> port_b_out_o ==
    ($past(port_b_out_o) & ~(8'h01 << $past(acc_bit_i)))) else $error("bit clear wrong");
  a_skip_sel: assert property (s_skip_b |=> acc_skip_o == $past(bsel))
    else $error("skip wrong");
  a_store_map: assert property (mem_k && acc_kind_i == `IOSD_K_STORE &&
    acc_addr_i == 8'h24 |=> port_b_dir_o == $past(acc_wdata_i)) else $error("map wrong");
endmodule // iosd_chk

// ==== bench/iosd_core_model.sv ====
module iosd_core_model (
  // Core clock
  input logic clk_i,
  // Request side
  output logic req_o,
  output logic [2:0] kind_o,
  output logic [7:0] addr_o,
  output logic [2:0] bit_o,
  output logic [7:0] wdata_o,
  // Answer side
  input logic done_i,
  input logic [7:0] rdata_i,
  input logic skip_i,
  input logic err_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rd;
  logic sk;
  logic er;
  logic hung;
  initial begin
    req_o = 1'b0;
    kind_o = 3'h0;
    addr_o = 8'h00;
    bit_o = 3'h0;
    wdata_o = 8'h00;
  end
  // Callers may pass ones in reserved bits and may access reserved places
  task automatic acc(input logic [2:0] k, input logic [7:0] a, input logic [2:0] b,
                     input logic [7:0] d);
    @(negedge clk_i);
    req_o = 1'b1;
    kind_o = k;
    addr_o = a;
    bit_o = b;
    wdata_o = d;
    @(negedge clk_i);
    req_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
    for (int i = 0; i < 3 && done_i !== 1'b1; i++) @(negedge clk_i);
    hung = done_i !== 1'b1;
    rd = rdata_i;
    sk = skip_i;
    er = err_i;
  endtask
endmodule // iosd_core_model

// ==== bench/tb_iosd_top.sv ====
`include "iosd_regs.vh"

module tb_iosd_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i, reset_n_i, acc_req_i, acc_done_o, acc_skip_o, acc_err_o;
  logic [2:0] acc_kind_i, acc_bit_i;
  logic [7:0] acc_addr_i, acc_wdata_i, acc_rdata_o, pa, pb, pc, pd, t0, t1;
  logic [7:0] a_dir, a_out, b_dir, b_out, c_dir, c_out, d_dir, d_out;
  int err_count, n_checks;

  iosd_top i_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .acc_req_i(acc_req_i),
    .acc_kind_i(acc_kind_i), .acc_addr_i(acc_addr_i), .acc_bit_i(acc_bit_i),
    .acc_wdata_i(acc_wdata_i), .acc_done_o(acc_done_o), .acc_rdata_o(acc_rdata_o),
    .acc_skip_o(acc_skip_o), .acc_err_o(acc_err_o), .port_a_pin_i(pa), .port_b_pin_i(pb),
    .port_c_pin_i(pc), .port_d_pin_i(pd), .port_a_dir_o(a_dir), .port_a_out_o(a_out),
    .port_b_dir_o(b_dir), .port_b_out_o(b_out), .port_c_dir_o(c_dir), .port_c_out_o(c_out),
    .port_d_dir_o(d_dir), .port_d_out_o(d_out), .tmr0_evt_i(t0), .tmr1_evt_i(t1));
  iosd_core_model i_core (.clk_i(ref_clk_i), .req_o(acc_req_i), .kind_o(acc_kind_i),
    .addr_o(acc_addr_i), .bit_o(acc_bit_i), .wdata_o(acc_wdata_i), .done_i(acc_done_o),
    .rdata_i(acc_rdata_o), .skip_i(acc_skip_o), .err_i(acc_err_o));

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Result word: hang, refused, skip, spare, read data
  task automatic go(input logic [2:0] k, input logic [7:0] a, input logic [2:0] b,
                    input logic [7:0] d, input logic [11:0] exp);
    i_core.acc(k, a, b, d);
    chk({i_core.hung, i_core.er, i_core.sk, 1'b0, i_core.rd}, exp);
  endtask

  task automatic t_map;
    go(`IOSD_K_IN, 8'h05, 3'h0, 8'h00, 12'h000);
    go(`IOSD_K_OUT, 8'h04, 3'h0, 8'hA5, 12'h000);
    chk({4'h0, b_dir}, 12'h0A5);
    go(`IOSD_K_LOAD, 8'h24, 3'h0, 8'h00, 12'h0A5);
    go(`IOSD_K_STORE, 8'h28, 3'h0, 8'h5A, 12'h000);
    chk({4'h0, c_out}, 12'h05A);
    go(`IOSD_K_IN, 8'h08, 3'h0, 8'h00, 12'h05A);
    go(`IOSD_K_IN, 8'h06, 3'h0, 8'h00, 12'h0C3);
    go(`IOSD_K_LOAD, 8'h29, 3'h0, 8'h00, 12'h03C);
    go(`IOSD_K_STORE, 8'h66, 3'h0, 8'h3C, 12'h000);
    go(`IOSD_K_LOAD, 8'h66, 3'h0, 8'h00, 12'h03C);
    go(`IOSD_K_STORE, 8'h24, 3'h0, 8'h6C, 12'h000);
    chk({4'h0, b_dir}, 12'h06C);
    go(`IOSD_K_STORE, 8'h2A, 3'h0, 8'h96, 12'h000);
    chk({4'h0, d_dir}, 12'h096);
    go(`IOSD_K_OUT, 8'h0B, 3'h0, 8'h69, 12'h000);
    chk({4'h0, d_out}, 12'h069);
    go(`IOSD_K_OUT, 8'h07, 3'h0, 8'h11, 12'h000);
    chk({4'h0, c_dir}, 12'h011);
    go(`IOSD_K_STORE, 8'h2D, 3'h0, 8'hF3, 12'h000);
    chk({4'h0, a_dir}, 12'h003);
  endtask

  task automatic t_range;
    logic [10:0] tbl [8] = '{{`IOSD_K_IN, 8'h40}, {`IOSD_K_OUT, 8'hFF},
      {`IOSD_K_SET, 8'h20}, {`IOSD_K_CLR, 8'h3F}, {`IOSD_K_SKIPH, 8'h20},
      {`IOSD_K_SKIPL, 8'h3F}, {`IOSD_K_LOAD, 8'h1F}, {`IOSD_K_STORE, 8'h60 - 8'h41}};
    foreach (tbl[i]) go(tbl[i][10:8], tbl[i][7:0], 3'h0, 8'hFF, 12'h400);
    chk({4'h0, c_out}, 12'h05A);
    go(`IOSD_K_SET, 8'h1F, 3'h0, 8'h00, 12'h000);
    go(`IOSD_K_IN, 8'h3F, 3'h0, 8'h00, 12'h000);
    go(`IOSD_K_IN, 8'h1F, 3'h0, 8'h00, 12'h001);
  endtask

  task automatic t_bits;
    for (int b = 0; b < 8; b++) begin
      go(`IOSD_K_SET, 8'h05, b[2:0], 8'h00, 12'h000);
      chk({4'h0, b_out}, {4'h0, 8'hFF >> (7 - b)});
    end
    go(`IOSD_K_CLR, 8'h05, 3'h3, 8'h00, 12'h000);
    chk({4'h0, b_out}, 12'h0F7);
    go(`IOSD_K_SKIPH, 8'h05, 3'h3, 8'h00, 12'h000);
    go(`IOSD_K_SKIPL, 8'h05, 3'h3, 8'h00, 12'h200);
    pb = 8'h5A;
    for (int b = 0; b < 8; b++) begin
      go(`IOSD_K_SKIPH, 8'h03, b[2:0], 8'h00, {2'b00, pb[b], 9'h000});
      go(`IOSD_K_SKIPL, 8'h03, b[2:0], 8'h00, {2'b00, !pb[b], 9'h000});
    end
  endtask

  task automatic t_flags;
    t0 = 8'hFF;
    t1 = 8'hFF;
    @(negedge ref_clk_i);
    t0 = 8'h00;
    t1 = 8'h00;
    go(`IOSD_K_IN, 8'h15, 3'h0, 8'h00, 12'h007);
    go(`IOSD_K_LOAD, 8'h36, 3'h0, 8'h00, 12'h027);
    go(`IOSD_K_OUT, 8'h15, 3'h0, 8'h02, 12'h000);
    go(`IOSD_K_IN, 8'h15, 3'h0, 8'h00, 12'h005);
    go(`IOSD_K_SET, 8'h15, 3'h0, 8'h00, 12'h000);
    go(`IOSD_K_IN, 8'h15, 3'h0, 8'h00, 12'h004);
    go(`IOSD_K_CLR, 8'h15, 3'h2, 8'h00, 12'h000);
    go(`IOSD_K_IN, 8'h15, 3'h0, 8'h00, 12'h004);
    go(`IOSD_K_STORE, 8'h36, 3'h0, 8'h00, 12'h000);
    go(`IOSD_K_LOAD, 8'h36, 3'h0, 8'h00, 12'h027);
  endtask

  // Deliberately writes reserved bits and places
  task automatic t_resv;
    go(`IOSD_K_IN, 8'h00, 3'h0, 8'h00, 12'h000);
    go(`IOSD_K_IN, 8'h0C, 3'h0, 8'h00, 12'h00F);
    go(`IOSD_K_OUT, 8'h0E, 3'h0, 8'hFF, 12'h000);
    chk({4'h0, a_out}, 12'h00F);
    go(`IOSD_K_IN, 8'h0E, 3'h0, 8'h00, 12'h00F);
    go(`IOSD_K_STORE, 8'h77, 3'h0, 8'h55, 12'h000);
    go(`IOSD_K_LOAD, 8'h77, 3'h0, 8'h00, 12'h000);
  endtask

  task automatic wrap_up;
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    err_count = 0;
    n_checks = 0;
    pa = 8'hFF;
    pb = 8'h00;
    pc = 8'hC3;
    pd = 8'h3C;
    t0 = 8'h00;
    t1 = 8'h00;
    reset_n_i = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    t_map;
    t_range;
    t_bits;
    t_flags;
    t_resv;
    wrap_up;
  end
endmodule // tb_iosd_top

bind iosd_top iosd_chk i_chk (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
  .acc_req_i(acc_req_i), .acc_kind_i(acc_kind_i), .acc_addr_i(acc_addr_i),
  .acc_bit_i(acc_bit_i), .acc_wdata_i(acc_wdata_i), .acc_done_o(acc_done_o),
  .acc_rdata_o(acc_rdata_o), .acc_skip_o(acc_skip_o), .acc_err_o(acc_err_o),
  .port_b_dir_o(port_b_dir_o), .port_b_out_o(port_b_out_o));
